// file: rtl/dtc_pkg.sv
// Package for the dual timer with capture/reload block
// Assumes a single 40 MHz system clock and synchronous pin inputs
`default_nettype none
package dtc_pkg;
  // Counter width
  localparam int TMR_WIDTH = 16;
  // Base step: one count slot per this many clocks
  localparam int BASE_STEP = 2;
  // Prescaler select width (divide by 2**n base steps)
  localparam int PRE_WIDTH = 3;
  // Reset values
  localparam logic [15:0] TMR_RESET = 16'h0000;
  // Timer clock source select
  typedef enum logic [1:0]
  {
    SRC_PRESCALE = 2'b00, // Prescaled system clock
    SRC_PIN      = 2'b01, // External count pin edge
    SRC_LATCH    = 2'b10, // Core toggle latch edge (aux only)
    SRC_STOP     = 2'b11  // Stopped
  } dtc_src_type;
  // Edge select
  typedef enum logic [1:0]
  {
    EDGE_NONE = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } dtc_edge_type;
  // Edge detect with selection
  function automatic logic edge_hit(input logic now, input logic prev, input dtc_edge_type sel);
    edge_hit = (sel[0] && now && !prev) || (sel[1] && !now && prev);
  endfunction : edge_hit
endpackage : dtc_pkg
`default_nettype wire

// file: rtl/dtc_timer.sv
// One 16-bit up/down timer with tick, direction, load and clear control
// Assumes all trigger inputs are already synchronous single-cycle events
`default_nettype none
module dtc_timer
  import dtc_pkg::*;
#(
  parameter int WIDTH = TMR_WIDTH
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Count control
  input  wire logic             countTick,
  input  wire logic             countDown,
  // Load and clear
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] loadValue,
  input  wire logic             clear,
  // State
  output logic      [WIDTH-1:0] value,
  output logic                  wrap
);
  // Terminal values for wrap detection
  wire atMax = &value;
  wire atMin = ~|value;
  // Wrap event when a tick passes the end
  assign wrap = countTick && (countDown ? atMin : atMax);
  wire [WIDTH-1:0] stepped = countDown ? value - 1'b1 : value + 1'b1;
  // Counter register; clear beats load beats count
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      value <= '0;
    else if (clear)
      value <= '0;
    else if (load)
      value <= loadValue;
    else if (countTick)
      value <= stepped;
  end
endmodule : dtc_timer
`default_nettype wire

// file: rtl/dtc_timer_unit.sv
// Second timer module: aux timer, core timer, capture/reload register
// Assumes pins are synchronous to clk but may still be metastable-prone
`default_nettype none
module dtc_timer_unit
  import dtc_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // External pins
  input  wire logic                 auxCountPin,
  input  wire logic                 auxDirPin,
  input  wire logic                 coreCountPin,
  input  wire logic                 coreDirPin,
  input  wire logic                 capturePin,
  input  wire logic                 firstCountPin,
  input  wire logic                 firstDirPin,
  // Aux timer configuration
  input  wire dtc_src_type          auxSrc,
  input  wire logic [PRE_WIDTH-1:0] auxPrescale,
  input  wire logic                 auxDown,
  input  wire logic                 auxDirPinEn,
  input  wire dtc_edge_type         auxPinEdge,
  // Core timer configuration
  input  wire dtc_src_type          coreSrc,
  input  wire logic [PRE_WIDTH-1:0] corePrescale,
  input  wire logic                 coreDown,
  input  wire logic                 coreDirPinEn,
  input  wire dtc_edge_type         corePinEdge,
  input  wire logic                 reloadEn,
  input  wire logic                 toggleOutEn,
  // Capture configuration
  input  wire dtc_edge_type         captureEdge,
  input  wire logic                 captureFromFirst,
  input  wire dtc_edge_type         firstCountEdge,
  input  wire dtc_edge_type         firstDirEdge,
  input  wire logic                 clearAfterCapture,
  // Flag clears from software
  input  wire logic                 auxFlagClr,
  input  wire logic                 coreFlagClr,
  input  wire logic                 captureFlagClr,
  // State and outputs
  output logic [TMR_WIDTH-1:0]      auxValue,
  output logic [TMR_WIDTH-1:0]      coreValue,
  output logic [TMR_WIDTH-1:0]      captureReloadReg,
  output logic                      coreToggleLatch,
  output logic                      toggleOutputPin,
  output logic                      compareClockTick,
  output logic                      auxFlag,
  output logic                      coreFlag,
  output logic                      captureFlag
);
  localparam int NPIN = 7;
  // Two-stage synchronisers for all pins
  wire [NPIN-1:0] pinRaw = {firstDirPin, firstCountPin, capturePin, coreDirPin,
                            coreCountPin, auxDirPin, auxCountPin};
  logic [NPIN-1:0] syncA;
  logic [NPIN-1:0] syncB;
  logic [NPIN-1:0] syncC;
  // Synchroniser and history chain
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      syncA <= '0;
      syncB <= '0;
      syncC <= '0;
    end
    else
    begin
      syncA <= pinRaw;
      syncB <= syncA;
      syncC <= syncB;
    end
  end
  // Base step strobe, every second clock
  logic baseDiv;
  logic [7:0] preCount;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      baseDiv <= 1'b0;
    else
      baseDiv <= ~baseDiv;
  end
  wire baseStep = baseDiv;
  // Free prescale counter of base steps
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      preCount <= 8'h00;
    else if (baseStep)
      preCount <= preCount + 8'h01;
  end
  // Prescaled slot: all low bits below the select are ones
  // Pure function of its arguments, so callers gate it with baseStep
  function automatic logic pre_tick(input logic [7:0] cnt, input logic [PRE_WIDTH-1:0] sel);
    logic [7:0] mask;
    mask = 8'((9'h001 << sel) - 9'h001);
    pre_tick = ((cnt & mask) == mask);
  endfunction : pre_tick
  // Pin edge events, each a one-cycle pulse from the synchronised level and its history bit
  wire auxPinEv   = edge_hit(syncB[0], syncC[0], auxPinEdge);
  wire corePinEv  = edge_hit(syncB[2], syncC[2], corePinEdge);
  wire captureEv  = edge_hit(syncB[4], syncC[4], captureEdge);
  wire firstEv    = captureFromFirst &&
                    (edge_hit(syncB[5], syncC[5], firstCountEdge) ||
                     edge_hit(syncB[6], syncC[6], firstDirEdge));
  wire captureHit = captureEv || firstEv;
  // Pending pin and latch counts held until the next base step
  logic auxPend;
  logic corePend;
  logic latchPend;
  wire coreWrap;
  wire auxWrap;
  // Core and aux timer tick selection
  wire coreTick = (coreSrc == SRC_PRESCALE) ? baseStep && pre_tick(preCount, corePrescale) :
                  (coreSrc == SRC_PIN)      ? baseStep && corePend : 1'b0;
  wire auxTick  = (auxSrc == SRC_PRESCALE)  ? baseStep && pre_tick(preCount, auxPrescale) :
                  (auxSrc == SRC_PIN)       ? baseStep && auxPend :
                  (auxSrc == SRC_LATCH)     ? baseStep && latchPend : 1'b0;
  // Direction: pin level overrides when enabled
  wire auxDir  = auxDirPinEn  ? syncB[1] : auxDown;
  wire coreDir = coreDirPinEn ? syncB[3] : coreDown;
  // Pending event capture, set wins over consume
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      auxPend   <= 1'b0;
      corePend  <= 1'b0;
      latchPend <= 1'b0;
    end
    else
    begin
      auxPend   <= auxPinEv  || (auxPend  && !baseStep);
      corePend  <= corePinEv || (corePend && !baseStep);
      latchPend <= coreWrap  || (latchPend && !baseStep);
    end
  end
  // Aux timer; cleared after capture when enabled
  dtc_timer #(.WIDTH(TMR_WIDTH)) u_aux
  (
    .clk       (clk),
    .rst       (rst),
    .countTick (auxTick),
    .countDown (auxDir),
    .load      (1'b0),
    .loadValue (TMR_RESET),
    .clear     (captureHit && clearAfterCapture),
    .value     (auxValue),
    .wrap      (auxWrap)
  );
  // Core timer; reloads from capture/reload register on wrap
  dtc_timer #(.WIDTH(TMR_WIDTH)) u_core
  (
    .clk       (clk),
    .rst       (rst),
    .countTick (coreTick),
    .countDown (coreDir),
    .load      (coreWrap && reloadEn),
    .loadValue (captureReloadReg),
    .clear     (1'b0),
    .value     (coreValue),
    .wrap      (coreWrap)
  );
  // Capture register and toggle latch
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      captureReloadReg <= TMR_RESET;
      coreToggleLatch  <= 1'b0;
      toggleOutputPin  <= 1'b0;
      compareClockTick <= 1'b0;
    end
    else
    begin
      if (captureHit)
        captureReloadReg <= auxValue;
      if (coreWrap)
        coreToggleLatch <= ~coreToggleLatch;
      toggleOutputPin  <= toggleOutEn && (coreToggleLatch ^ coreWrap);
      compareClockTick <= coreWrap;
    end
  end
  // Request flags, set wins over clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      auxFlag     <= 1'b0;
      coreFlag    <= 1'b0;
      captureFlag <= 1'b0;
    end
    else
    begin
      auxFlag     <= auxWrap    || (auxFlag && !auxFlagClr);
      coreFlag    <= coreWrap   || (coreFlag && !coreFlagClr);
      captureFlag <= captureHit || (captureFlag && !captureFlagClr);
    end
  end
  // Checks
  toggle_flip_a: assert property (@(posedge clk) disable iff (rst)
    coreWrap |=> coreToggleLatch != $past(coreToggleLatch))
    else $error("toggle latch did not invert on wrap");
  toggle_hold_a: assert property (@(posedge clk) disable iff (rst)
    !coreWrap |=> $stable(coreToggleLatch))
    else $error("toggle latch changed without wrap");
  capture_copy_a: assert property (@(posedge clk) disable iff (rst)
    captureHit |=> captureReloadReg == $past(auxValue))
    else $error("capture did not copy aux timer");
  capture_clear_a: assert property (@(posedge clk) disable iff (rst)
    captureHit && clearAfterCapture |=> auxValue == 16'h0000)
    else $error("aux timer not cleared after capture");
  core_reload_a: assert property (@(posedge clk) disable iff (rst)
    coreWrap && reloadEn |=> coreValue == $past(captureReloadReg))
    else $error("core timer not reloaded");
  step_rate_a: assert property (@(posedge clk) disable iff (rst)
    coreTick |=> !coreTick)
    else $error("core timer counted faster than two clocks");
  core_flag_a: assert property (@(posedge clk) disable iff (rst)
    coreWrap |=> coreFlag)
    else $error("core flag not raised on wrap");
  capture_flag_a: assert property (@(posedge clk) disable iff (rst)
    captureHit |=> captureFlag)
    else $error("capture flag not raised");
  direction_a: assert property (@(posedge clk) disable iff (rst)
    coreTick && !coreWrap && !coreDir |=> coreValue == 16'($past(coreValue) + 16'h0001))
    else $error("core timer did not count up");
endmodule : dtc_timer_unit
`default_nettype wire

// file: verif/dtc_pin_model.sv
// Partner model: an external pulse source on a count pin
// Assumes the bench asks for a burst with a one-cycle go strobe
`default_nettype none
module dtc_pin_model
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Burst request
  input  wire logic       go,
  input  wire logic [3:0] num,
  // Pin driven
  output var  logic       pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] left; // Pulses still owed
  logic [1:0] ph;   // Phase within a pulse
  // One pulse per four clocks, so no edge is closer than one base step
  always @(negedge clk or posedge rst)
  begin
    if (rst)
      {left, ph, pin} <= 7'h00;
    else if (go)
      {left, ph} <= {num, 2'h0};
    else if (left != 4'h0)
    begin
      ph   <= ph + 2'h1;
      pin  <= (ph < 2'h2);
      left <= (ph == 2'h3) ? left - 4'h1 : left;
    end
  end
endmodule : dtc_pin_model
`default_nettype wire

// file: verif/dual_timer_capture_reload_tb_top.sv
// Bench for the dual timer unit: counting, capture, reload, toggle latch
// Assumes one 40 MHz clock; inputs change on the falling edge
`default_nettype none
module dual_timer_capture_reload_tb_top
  import dtc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, auxCountPin, auxDirPin, coreCountPin, coreDirPin, capturePin;
  logic firstCountPin, firstDirPin, auxDown, auxDirPinEn, coreDown, coreDirPinEn;
  logic reloadEn, toggleOutEn, captureFromFirst, clearAfterCapture, go;
  logic auxFlagClr, coreFlagClr, captureFlagClr, coreToggleLatch, toggleOutputPin;
  logic compareClockTick, auxFlag, coreFlag, captureFlag;
  logic [3:0] num;
  logic [PRE_WIDTH-1:0] auxPrescale, corePrescale;
  dtc_src_type auxSrc, coreSrc;
  dtc_edge_type auxPinEdge, corePinEdge, captureEdge, firstCountEdge, firstDirEdge;
  logic [TMR_WIDTH-1:0] auxValue, coreValue, captureReloadReg, mark;
  int fails = 0, n_compared = 0, ticks = 0, cyc = 0, t0;
  // Device under test
  dtc_timer_unit u_dtc_timer_unit (.clk, .rst, .auxCountPin, .auxDirPin, .coreCountPin,
    .coreDirPin, .capturePin, .firstCountPin, .firstDirPin, .auxSrc, .auxPrescale, .auxDown,
    .auxDirPinEn, .auxPinEdge, .coreSrc, .corePrescale, .coreDown, .coreDirPinEn, .corePinEdge,
    .reloadEn, .toggleOutEn, .captureEdge, .captureFromFirst, .firstCountEdge, .firstDirEdge,
    .clearAfterCapture, .auxFlagClr, .coreFlagClr, .captureFlagClr, .auxValue, .coreValue,
    .captureReloadReg, .coreToggleLatch, .toggleOutputPin, .compareClockTick, .auxFlag,
    .coreFlag, .captureFlag);
  // Pulse source on the aux count pin
  dtc_pin_model u_dtc_pin_model (.clk, .rst, .go, .num, .pin(auxCountPin));
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Cycle count, compare-clock pulse count and hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    ticks <= ticks + (compareClockTick === 1'b1);
    if (cyc == 3000)
    begin
      fails++;
      stop_test();
    end
  end
  task automatic stop_test;
    if (fails == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  // Compare of a value or flag, four-state exact
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc_n(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc_n
  // Burst of pulses from the partner, then time for sync and count
  task automatic burst(input logic [3:0] n);
    go <= 1'b1;
    num <= n;
    cyc_n(1);
    go <= 1'b0;
    cyc_n(4 * n + 6);
  endtask : burst
  // High pulse on a pin, long enough to pass the synchroniser
  task automatic pulse(ref logic p);
    p = 1'b1;
    cyc_n(5);
    p = 1'b0;
    cyc_n(5);
  endtask : pulse
  task automatic clr_cap;
    pulse(captureFlagClr);
    chk(captureFlag, 16'h0000);
  endtask : clr_cap
  // Prescaled count rate at the two finest settings
  task automatic t_prescale;
    auxSrc = SRC_PRESCALE;
    for (int i = 0; i < 2; i++)
    begin
      auxPrescale = PRE_WIDTH'(i);
      cyc_n(8);
      mark = auxValue;
      cyc_n(40);
      chk(auxValue - mark, 16'(20 >> i));
    end
    auxSrc = SRC_STOP;
    captureEdge = EDGE_RISE;
    clearAfterCapture = 1'b1;
    pulse(capturePin);
    chk(auxValue, 16'h0000);
    chk(captureFlag, 16'h0001);
    clr_cap();
  endtask : t_prescale
  // Pin counting with pin direction, wrap flag, capture from first module
  task automatic t_pin_dir;
    auxSrc = SRC_PIN;
    auxPinEdge = EDGE_RISE;
    {auxDirPinEn, auxDirPin, clearAfterCapture} = 3'h6;
    cyc_n(4);
    burst(4'h2);
    chk(auxValue, 16'hfffe);
    chk(auxFlag, 16'h0001);
    pulse(auxFlagClr);
    chk(auxFlag, 16'h0000);
    captureFromFirst = 1'b1;
    captureEdge = EDGE_NONE;
    firstCountEdge = EDGE_RISE;
    pulse(firstCountPin);
    chk(captureReloadReg, 16'hfffe);
    {captureFromFirst, auxDirPin} = 2'h0;
    cyc_n(4);
    burst(4'h5);
    chk(auxValue, 16'h0003);
  endtask : t_pin_dir
  // Falling-edge capture with clear; rising edge must not capture
  task automatic t_capture;
    captureEdge = EDGE_FALL;
    clearAfterCapture = 1'b1;
    clr_cap();
    capturePin = 1'b1;
    cyc_n(6);
    chk(captureFlag, 16'h0000);
    capturePin = 1'b0;
    cyc_n(6);
    chk(captureReloadReg, 16'h0003);
    chk(auxValue, 16'h0000);
    chk(captureFlag, 16'h0001);
  endtask : t_capture
  // Core counts prescaled ticks down by pin direction, reloads 3 on each wrap: one wrap per 8 clocks
  task automatic t_reload;
    auxSrc = SRC_LATCH;
    auxDirPinEn = 1'b0;
    coreSrc = SRC_PRESCALE;
    {coreDirPinEn, coreDirPin, reloadEn, toggleOutEn} = 4'hf;
    cyc_n(30);
    mark = auxValue;
    t0 = ticks;
    cyc_n(80);
    chk(auxValue - mark, 16'h000a);
    chk(16'(ticks - t0), 16'h000a);
    chk(coreValue <= 16'h0003, 16'h0001);
    chk(coreFlag, 16'h0001);
    chk(toggleOutputPin, coreToggleLatch);
    // One wrap per 8 clocks, so the latch has inverted once
    mark = 16'(coreToggleLatch);
    cyc_n(8);
    chk(coreToggleLatch, mark ^ 16'h0001);
    chk(toggleOutputPin, mark ^ 16'h0001);
    toggleOutEn = 1'b0;
    cyc_n(2);
    chk(toggleOutputPin, 16'h0000);
  endtask : t_reload
  // Core counts both pin edges upward; capture on both first-module direction edges
  task automatic t_core_pin;
    coreSrc = SRC_PIN;
    corePinEdge = EDGE_BOTH;
    {coreDirPinEn, coreDown, reloadEn} = 3'h0;
    pulse(coreFlagClr);
    chk(coreFlag, 16'h0000);
    mark = coreValue;
    pulse(coreCountPin);
    chk(coreValue - mark, 16'h0002);
    clr_cap();
    captureFromFirst = 1'b1;
    firstDirEdge = EDGE_BOTH;
    pulse(firstDirPin);
    chk(captureReloadReg, 16'h0000);
    chk(auxValue, 16'h0000);
    chk(captureFlag, 16'h0001);
  endtask : t_core_pin
  // Main sequence
  initial
  begin
    {rst, num, auxPrescale, corePrescale} = {1'b1, 10'h000};
    {auxDirPin, coreCountPin, coreDirPin, capturePin, firstCountPin, firstDirPin, auxDown,
      auxDirPinEn, coreDown, coreDirPinEn, reloadEn, toggleOutEn, captureFromFirst,
      clearAfterCapture, auxFlagClr, coreFlagClr, captureFlagClr, go} = '0;
    auxSrc = SRC_STOP;
    coreSrc = SRC_STOP;
    auxPinEdge = EDGE_NONE;
    corePinEdge = EDGE_NONE;
    captureEdge = EDGE_NONE;
    firstCountEdge = EDGE_NONE;
    firstDirEdge = EDGE_NONE;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    cyc_n(2);
    chk(auxValue | coreValue | captureReloadReg, 16'h0000);
    t_prescale();
    t_pin_dir();
    t_capture();
    t_reload();
    t_core_pin();
    stop_test();
  end
endmodule : dual_timer_capture_reload_tb_top
`default_nettype wire
